// [design/lss_pkg.sv]
// Shared constants and types for the line switch sequencer.
// Assumes a single 100 MHz clock; all sequence times are counted in 1 us ticks.
`default_nettype none
package lss_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 10;      // System clock period
	localparam int TICK_NS       = 1000;    // Sequencer time base, 1 us
	localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int US_PER_MS     = 1000;    // Ticks in one millisecond
	// Nominal sequence times, in milliseconds
	localparam int ON_RELAY_MS   = 50;      // Gate asserted to relay energised
	localparam int ON_RELEASE_MS = 20;      // Relay energised to gate removed
	localparam int OFF_RELAY_MS  = 20;      // Gate asserted to relay dropped
	localparam int OFF_RELEASE_MS = 40;     // Relay dropped to gate removed
	// Derived tick counts
	localparam int ON_RELAY_US    = ON_RELAY_MS * US_PER_MS;
	localparam int ON_RELEASE_US  = ON_RELEASE_MS * US_PER_MS;
	localparam int OFF_RELAY_US   = OFF_RELAY_MS * US_PER_MS;
	localparam int OFF_RELEASE_US = OFF_RELEASE_MS * US_PER_MS;
	// Widths
	localparam int CNT_W   = 17;            // Tick counter, holds 50 ms
	localparam int PHASE_W = 16;            // Programmed phase delay in us
	localparam int DAC_W   = 16;            // Offset DAC setting
	localparam int IN_W    = 2;             // Input select
	localparam int RNG_W   = 3;             // Range select
	localparam int SHT_W   = 1;             // Shunt select
	localparam logic [DAC_W-1:0] DAC_RST = 16'h8000; // Mid-scale shown after reset
	// Sequencer states
	typedef enum logic [2:0] {
		LSS_OFF       = 3'b000,
		LSS_WAIT_EDGE = 3'b001,
		LSS_PHASE     = 3'b010,
		LSS_GATE_ON   = 3'b011,
		LSS_OVERLAP   = 3'b100,
		LSS_ON        = 3'b101,
		LSS_OFF_GATE  = 3'b110,
		LSS_OFF_HOLD  = 3'b111
	} lss_state_t;
endpackage
`default_nettype wire

// [design/lss_zero_if.sv]
// Carrier between the sequencer top and its offset setting store.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface lss_zero_if
	import lss_pkg::*;
	();
	logic [IN_W-1:0]  sel_input;  // Input being addressed
	logic [RNG_W-1:0] sel_range;  // Range being addressed
	logic [SHT_W-1:0] sel_shunt;  // Shunt being addressed
	logic             wr;         // Store a new setting
	logic [DAC_W-1:0] wdata;      // Setting to store
	logic [DAC_W-1:0] rdata;      // Setting for the current selection
	modport ctrl  (output sel_input, sel_range, sel_shunt, wr, wdata, input rdata);
	modport store (input sel_input, sel_range, sel_shunt, wr, wdata, output rdata);
endinterface
`default_nettype wire

// [design/lss_offset_store.sv]
// Per input, range and shunt offset DAC settings.
// Assumes the array maps onto retained storage; it is not cleared by reset.
`timescale 1ns/100ps
`default_nettype none
module lss_offset_store
	import lss_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	lss_zero_if.store zif
);
	localparam int ADDR_W = IN_W + RNG_W + SHT_W;
	localparam int DEPTH  = 1 << ADDR_W;

	logic [DAC_W-1:0]  mem [DEPTH];     // One setting per combination
	logic [ADDR_W-1:0] addr;            // Flattened selection
	logic [DAC_W-1:0]  rdata;           // Registered readout

	// Each combination has its own slot, so no zero result overwrites another
	assign addr = {zif.sel_input, zif.sel_range, zif.sel_shunt};

	// Storage has no reset: settings must survive a restart
	always_ff @(posedge clk)
	begin
		if (zif.wr)
			mem[addr] <= zif.wdata;
	end

	// Readout register drives the DAC, so it gets a defined reset value
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdata <= DAC_RST;
		else if (zif.wr)
			rdata <= zif.wdata;
		else
			rdata <= mem[addr];
	end

	assign zif.rdata = rdata;
endmodule
`default_nettype wire

// [design/line_switch_sequencer.sv]
// Line switch sequencer: drives a TRIAC gate and a parallel relay coil.
// Assumes on/off commands are one-cycle pulses and all inputs are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Drive gate and relay only on commands
// - AC on: comparator edge, then programmed delay
// - DC on: gate asserted at once
// - Relay energised 50 ms after gate
// - Gate removed 20 ms after relay
// - DC off: drop relay at once only
// - AC off: assert gate before relay changes
// - AC off: drop relay 20 ms later
// - AC off: remove gate 40 ms later
// - Processor trims each offset DAC to zero
// - One stored setting per input, range, shunt
module line_switch_sequencer
	import lss_pkg::*;
#(
	parameter int ON_RELAY_TICKS    = ON_RELAY_US,    // Gate to relay on
	parameter int ON_RELEASE_TICKS  = ON_RELEASE_US,  // Relay on to gate off
	parameter int OFF_RELAY_TICKS   = OFF_RELAY_US,   // Gate to relay off
	parameter int OFF_RELEASE_TICKS = OFF_RELEASE_US  // Relay off to gate off
)(
	input  wire logic               clk,
	input  wire logic               rst_b,
	input  wire logic               cmd_on,       // Switch on request pulse
	input  wire logic               cmd_off,      // Switch off request pulse
	input  wire logic               ac_mode,      // High for AC, low for DC
	input  wire logic [PHASE_W-1:0] phase_delay,  // Turn-on delay after edge, us
	input  wire logic               sq_in,        // Squared comparator, rising active
	input  wire logic [IN_W-1:0]    zero_input,   // Offset selection
	input  wire logic [RNG_W-1:0]   zero_range,
	input  wire logic [SHT_W-1:0]   zero_shunt,
	input  wire logic               zero_wr,      // Store trimmed setting
	input  wire logic [DAC_W-1:0]   zero_wdata,
	output logic                    triac_gate,   // TRIAC gate drive
	output logic                    relay_coil,   // Relay coil drive
	output logic                    busy,         // Sequence in progress
	output logic [DAC_W-1:0]        offset_dac    // Setting for selected combination
);
	lss_state_t       state;        // Sequencer state
	lss_state_t       next_state;
	logic             mode_ac;      // Mode latched at command acceptance
	logic [CNT_W-1:0] cnt;          // Ticks spent in current timed state
	logic [$clog2(TICK_CYC)-1:0] div; // Clock divider for the 1 us tick
	logic             tick;         // One-cycle 1 us enable
	logic             sq_prev;      // Comparator history for edge detect
	logic             sq_edge;      // Active comparator edge
	logic             pend_valid;   // Command waiting for a sequence to end
	logic             pend_on;      // Waiting command is on
	logic             want_on;      // On request visible at idle
	logic             want_off;     // Off request visible at idle
	logic             go_on;        // Turn-on accepted this cycle
	logic             go_off;       // Turn-off accepted this cycle
	logic             idle;         // In a resting state
	logic [CNT_W-1:0] limit;        // Tick limit for current state
	logic             timed;        // Current state is timed
	logic             expire;       // Current timed state ends
	lss_zero_if       zif ();       // Link to offset store

	// Time base divider
	assign tick = (div == ($clog2(TICK_CYC))'(TICK_CYC - 1));
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			div <= '0;
		else
			div <= tick ? '0 : div + 1'b1;
	end

	// Command decode; a request arriving mid-sequence waits in pend
	assign idle     = (state == LSS_OFF) || (state == LSS_ON);
	assign want_on  = cmd_on  || (pend_valid && pend_on);
	assign want_off = cmd_off || (pend_valid && !pend_on);
	assign go_on    = (state == LSS_OFF) && want_on;
	assign go_off   = (state == LSS_ON)  && want_off;
	assign busy     = !idle;
	assign sq_edge  = sq_in && !sq_prev;

	// Pending command: newest request wins, dropped at the first idle cycle whether acted on or not
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pend_valid <= 1'b0;
			pend_on    <= 1'b0;
		end
		else if (!idle && (cmd_on || cmd_off))
		begin
			pend_valid <= 1'b1;
			pend_on    <= cmd_on;
		end
		else if (idle)
			pend_valid <= 1'b0;
	end

	// Per-state time limit; phase state uses the programmed delay
	always_comb
	begin
		timed = 1'b1;
		limit = '0;
		unique case (state)
			LSS_PHASE:    limit = CNT_W'(phase_delay);
			LSS_GATE_ON:  limit = CNT_W'(ON_RELAY_TICKS);
			LSS_OVERLAP:  limit = CNT_W'(ON_RELEASE_TICKS);
			LSS_OFF_GATE: limit = CNT_W'(OFF_RELAY_TICKS);
			LSS_OFF_HOLD: limit = CNT_W'(OFF_RELEASE_TICKS);
			LSS_OFF, LSS_ON, LSS_WAIT_EDGE: timed = 1'b0;
		endcase
	end
	// A zero phase delay still waits for one tick; the error is under 1 us
	assign expire = timed && tick && (cnt + 1'b1 >= limit);

	// Next state
	always_comb
	begin
		next_state = state;
		unique case (state)
			LSS_OFF:
				if (go_on)
					next_state = ac_mode ? LSS_WAIT_EDGE : LSS_GATE_ON;
			LSS_WAIT_EDGE:
				if (sq_edge)
					next_state = LSS_PHASE;
			LSS_PHASE:
				if (expire)
					next_state = LSS_GATE_ON;
			LSS_GATE_ON:
				if (expire)
					next_state = LSS_OVERLAP;
			LSS_OVERLAP:
				if (expire)
					next_state = LSS_ON;
			LSS_ON:
				if (go_off)
					next_state = ac_mode ? LSS_OFF_GATE : LSS_OFF;
			LSS_OFF_GATE:
				if (expire)
					next_state = LSS_OFF_HOLD;
			LSS_OFF_HOLD:
				if (expire)
					next_state = LSS_OFF;
		endcase
	end

	// State, mode latch, counter and edge history
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state   <= LSS_OFF;
			mode_ac <= 1'b0;
			cnt     <= '0;
			sq_prev <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			sq_prev <= sq_in;
			if (go_on || go_off)
				mode_ac <= ac_mode;
			if (next_state != state)
				cnt <= '0;
			else if (tick && timed)
				cnt <= cnt + 1'b1;
		end
	end

	// Drive outputs from flops; glitch-free coil and gate
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			triac_gate <= 1'b0;
			relay_coil <= 1'b0;
		end
		else
		begin
			triac_gate <= (next_state == LSS_GATE_ON) || (next_state == LSS_OVERLAP)
				|| (next_state == LSS_OFF_GATE) || (next_state == LSS_OFF_HOLD);
			relay_coil <= (next_state == LSS_OVERLAP) || (next_state == LSS_ON)
				|| (next_state == LSS_OFF_GATE);
		end
	end

	// Zero trimming: processor writes, store keeps per combination
	assign zif.sel_input = zero_input;
	assign zif.sel_range = zero_range;
	assign zif.sel_shunt = zero_shunt;
	assign zif.wr        = zero_wr;
	assign zif.wdata     = zero_wdata;
	assign offset_dac    = zif.rdata;

	lss_offset_store u_store (
		.clk   (clk),
		.rst_b (rst_b),
		.zif   (zif)
	);

	// Checks
	sequence s_on_taken;
		(state == LSS_OFF) && cmd_on;
	endsequence
	sequence s_off_taken;
		(state == LSS_ON) && cmd_off;
	endsequence

	property p_dc_on;
		@(posedge clk) disable iff (!rst_b)
		s_on_taken and !ac_mode |=> triac_gate && !relay_coil;
	endproperty
	a_dc_on: assert property (p_dc_on) else $error("DC on gate late");

	property p_ac_on_wait;
		@(posedge clk) disable iff (!rst_b)
		s_on_taken and ac_mode |=> !triac_gate && (state == LSS_WAIT_EDGE);
	endproperty
	a_ac_on_wait: assert property (p_ac_on_wait) else $error("AC on skipped edge");

	property p_gate_rise;
		@(posedge clk) disable iff (!rst_b)
		$rose(triac_gate) && !relay_coil && mode_ac
			|-> $past(state) == LSS_PHASE;
	endproperty
	a_gate_rise: assert property (p_gate_rise) else $error("AC gate not after delay");

	property p_relay_on;
		@(posedge clk) disable iff (!rst_b)
		$rose(relay_coil) |-> $past(state) == LSS_GATE_ON
			&& $past(cnt) == CNT_W'(ON_RELAY_TICKS - 1) && triac_gate;
	endproperty
	a_relay_on: assert property (p_relay_on) else $error("Relay on timing");

	property p_gate_release_on;
		@(posedge clk) disable iff (!rst_b)
		$fell(triac_gate) && relay_coil
			|-> $past(cnt) == CNT_W'(ON_RELEASE_TICKS - 1) && state == LSS_ON;
	endproperty
	a_gate_release_on: assert property (p_gate_release_on) else $error("Gate release");

	property p_dc_off;
		@(posedge clk) disable iff (!rst_b)
		s_off_taken and !ac_mode |=> !relay_coil && !triac_gate ##1 !triac_gate;
	endproperty
	a_dc_off: assert property (p_dc_off) else $error("DC off wrong");

	property p_ac_off_gate;
		@(posedge clk) disable iff (!rst_b)
		s_off_taken and ac_mode |=> triac_gate && relay_coil;
	endproperty
	a_ac_off_gate: assert property (p_ac_off_gate) else $error("AC off gate late");

	property p_relay_off_ac;
		@(posedge clk) disable iff (!rst_b)
		$fell(relay_coil) && mode_ac |-> triac_gate
			&& $past(cnt) == CNT_W'(OFF_RELAY_TICKS - 1);
	endproperty
	a_relay_off_ac: assert property (p_relay_off_ac) else $error("AC relay off timing");

	property p_gate_release_off;
		@(posedge clk) disable iff (!rst_b)
		$fell(triac_gate) && !relay_coil |-> $past(state) == LSS_OFF_HOLD
			&& $past(cnt) == CNT_W'(OFF_RELEASE_TICKS - 1);
	endproperty
	a_gate_release_off: assert property (p_gate_release_off) else $error("Gate off timing");

	property p_no_interleave;
		@(posedge clk) disable iff (!rst_b)
		(state == LSS_GATE_ON) && cmd_off |=> state != LSS_OFF_GATE && state != LSS_OFF;
	endproperty
	a_no_interleave: assert property (p_no_interleave) else $error("Sequence cut");

	property p_store_readback;
		@(posedge clk) disable iff (!rst_b)
		zero_wr |=> offset_dac == $past(zero_wdata);
	endproperty
	a_store_readback: assert property (p_store_readback) else $error("Offset not kept");
endmodule
`default_nettype wire

// [tb/lss_dsp_model.sv]
// Signal processor model: issues switch commands and owns the comparator line.
// Assumes the bench calls its tasks; all changes land on falling clk edges.
`timescale 1ns/100ps
`default_nettype none
module lss_dsp_model
	import lss_pkg::*;
(
	input  wire logic               clk,
	output var logic                cmd_on,
	output var logic                cmd_off,
	output var logic                ac_mode,
	output var logic [PHASE_W-1:0]  phase_delay,
	output var logic                sq_in
);
	// Idle: no command, DC mode, comparator low
	initial
	begin
		cmd_on = 1'b0;
		cmd_off = 1'b0;
		ac_mode = 1'b0;
		phase_delay = 16'h0000;
		sq_in = 1'b0;
	end
	// One-cycle command pulse; mode and delay stay as levels afterwards
	task automatic send(input logic on, input logic ac, input logic [PHASE_W-1:0] ph);
		@(negedge clk);
		ac_mode = ac;
		phase_delay = ph;
		cmd_on = on;
		cmd_off = !on;
		@(negedge clk);
		cmd_on = 1'b0;
		cmd_off = 1'b0;
	endtask
	// Comparator level, moved only when a scenario asks for an edge
	task automatic sq(input logic v);
		@(negedge clk);
		sq_in = v;
	endtask
endmodule
`default_nettype wire

// [tb/line_switch_sequencer_tb_top.sv]
// Self-checking bench for the line switch sequencer.
// Assumes short stage counts; a tick is TICK_CYC clocks and may slip by one.
`timescale 1ns/100ps
`default_nettype none
module line_switch_sequencer_tb_top
	import lss_pkg::*;
();
	localparam int T1 = 5; // Gate to relay on
	localparam int T2 = 3; // Relay on to gate off
	localparam int T3 = 3; // Gate to relay off
	localparam int T4 = 4; // Relay off to gate off
	logic               clk, rst_b, cmd_on, cmd_off, ac_mode, sq_in, zero_wr;
	logic [PHASE_W-1:0] phase_delay;
	logic [IN_W-1:0]    zero_input;
	logic [RNG_W-1:0]   zero_range;
	logic [SHT_W-1:0]   zero_shunt;
	logic [DAC_W-1:0]   zero_wdata, offset_dac;
	logic               triac_gate, relay_coil, busy;
	int                 error_cnt, n_checks;
	lss_dsp_model lss_dsp_model_i (.clk(clk), .cmd_on(cmd_on), .cmd_off(cmd_off),
		.ac_mode(ac_mode), .phase_delay(phase_delay), .sq_in(sq_in));
	line_switch_sequencer #(.ON_RELAY_TICKS(T1), .ON_RELEASE_TICKS(T2),
		.OFF_RELAY_TICKS(T3), .OFF_RELEASE_TICKS(T4)) line_switch_sequencer_i (
		.clk(clk), .rst_b(rst_b), .cmd_on(cmd_on), .cmd_off(cmd_off),
		.ac_mode(ac_mode), .phase_delay(phase_delay), .sq_in(sq_in),
		.zero_input(zero_input), .zero_range(zero_range), .zero_shunt(zero_shunt),
		.zero_wr(zero_wr), .zero_wdata(zero_wdata), .triac_gate(triac_gate),
		.relay_coil(relay_coil), .busy(busy), .offset_dac(offset_dac));
	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Stage length within one tick of slip either way
	task automatic rng(input string nm, input int dt, input int lim);
		chk(nm, (dt >= (lim - 1) * TICK_CYC && dt <= (lim + 1) * TICK_CYC + 2), 1);
	endtask
	// Bounded wait for gate (s=0) or relay (s=1) to reach v; a hang gives a huge dt
	task automatic wait_for(input int s, input logic v, output int dt);
		dt = 0;
		while (((s == 0) ? triac_gate : relay_coil) !== v && dt < 5000)
		begin
			@(negedge clk);
			dt++;
		end
	endtask
	// Verdict, reached from the main sequence or the watchdog
	task automatic wrap_up();
		if (error_cnt == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_reset();
		chk("gate", triac_gate, 0);
		chk("relay", relay_coil, 0);
		chk("busy", busy, 0);
		chk("dac", offset_dac, DAC_RST);
	endtask
	task automatic t_dc_on();
		int dt;
		lss_dsp_model_i.send(1'b1, 1'b0, 16'h0000);
		@(negedge clk);
		chk("dc gate", triac_gate, 1);
		chk("busy", busy, 1);
		wait_for(1, 1'b1, dt);
		rng("on relay", dt, T1);
		wait_for(0, 1'b0, dt);
		rng("on release", dt, T2);
		chk("relay held", relay_coil, 1);
	endtask
	task automatic t_dc_off();
		lss_dsp_model_i.send(1'b0, 1'b0, 16'h0000);
		@(negedge clk);
		chk("dc off relay", relay_coil, 0);
		chk("dc off gate", triac_gate, 0);
	endtask
	task automatic t_ac_on();
		int dt;
		lss_dsp_model_i.send(1'b1, 1'b1, 16'h0003);
		repeat (400) @(negedge clk);
		chk("no edge gate", triac_gate, 0);
		lss_dsp_model_i.sq(1'b1);
		wait_for(0, 1'b1, dt);
		rng("phase", dt, 3);
		wait_for(1, 1'b1, dt);
		rng("ac relay", dt, T1);
		wait_for(0, 1'b0, dt);
		rng("ac release", dt, T2);
		lss_dsp_model_i.sq(1'b0);
	endtask
	task automatic t_ac_off();
		int dt;
		lss_dsp_model_i.send(1'b0, 1'b1, 16'h0003);
		@(negedge clk);
		chk("off gate", triac_gate, 1);
		chk("off relay kept", relay_coil, 1);
		wait_for(1, 1'b0, dt);
		rng("off relay", dt, T3);
		wait_for(0, 1'b0, dt);
		rng("off release", dt, T4);
		chk("busy", busy, 0);
	endtask
	// Reset in mid turn-on: outputs drop at once and stay idle after release
	task automatic t_mid_reset();
		lss_dsp_model_i.send(1'b1, 1'b0, 16'h0000);
		repeat (10) @(negedge clk);
		rst_b = 1'b0;
		repeat (2) @(negedge clk);
		chk("mid rst gate", triac_gate, 0);
		chk("mid rst busy", busy, 0);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		chk("post rst idle", {triac_gate, relay_coil, busy}, 0);
	endtask
	// Off arrives mid turn-on: the turn-on must finish first
	task automatic t_pending();
		int dt;
		lss_dsp_model_i.send(1'b1, 1'b0, 16'h0000);
		repeat (50) @(negedge clk);
		lss_dsp_model_i.send(1'b0, 1'b0, 16'h0000);
		wait_for(1, 1'b1, dt);
		rng("pend relay", dt + 52, T1);
		wait_for(0, 1'b0, dt);
		rng("pend release", dt, T2);
		wait_for(1, 1'b0, dt);
		chk("pend off", dt <= 5, 1);
		lss_dsp_model_i.send(1'b0, 1'b1, 16'h0000);
		repeat (20) @(negedge clk);
		chk("ignored off", {triac_gate, relay_coil, busy}, 0);
	endtask
	task automatic wr(input logic [5:0] sel, input logic [DAC_W-1:0] d);
		{zero_input, zero_range, zero_shunt} = sel;
		zero_wdata = d;
		zero_wr = 1'b1;
		@(negedge clk);
		chk("wr dac", offset_dac, d);
		// Strobe low for a full cycle so back-to-back writes never retoggle it at once
		zero_wr = 1'b0;
		@(negedge clk);
	endtask
	// Separate slots per selection, both ends of every field
	task automatic t_zero();
		wr(6'h00, 16'h1234);
		wr(6'h3F, 16'hABCD);
		wr(6'h15, 16'h5A5A);
		{zero_input, zero_range, zero_shunt} = 6'h00;
		repeat (2) @(negedge clk);
		chk("slot 0", offset_dac, 16'h1234);
		{zero_input, zero_range, zero_shunt} = 6'h3F;
		repeat (2) @(negedge clk);
		chk("slot 3F", offset_dac, 16'hABCD);
	endtask
	// Watchdog well beyond the expected few thousand cycles
	initial
	begin
		repeat (30000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
	// Main sequence
	initial
	begin
		error_cnt = 0;
		n_checks = 0;
		rst_b = 1'b0;
		zero_wr = 1'b0;
		zero_wdata = 16'h0000;
		{zero_input, zero_range, zero_shunt} = 6'h00;
		repeat (4) @(negedge clk);
		t_reset();
		rst_b = 1'b1;
		t_dc_on();
		t_dc_off();
		t_ac_on();
		t_ac_off();
		t_pending();
		t_mid_reset();
		t_zero();
		wrap_up();
	end
endmodule
`default_nettype wire
